// ===== charger_cfg.svh
// charger_cfg.svh: register offsets, fields, reset values and timing constants
// assumes a 20 MHz system clock and a 32-bit classic wishbone register bus
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CONTROL      8'h00
`define REG_CHARGE       8'h04
`define REG_STATUS       8'h08
`define REG_IRQ_STATUS   8'h0c
`define REG_IRQ_MASK     8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_STAT_EN      0
`define CTL_ACC_EN       1
`define CTL_CHG_EN       2
`define CTL_RESET_VAL    32'h0000_0001

// ----------------------------------------------------------------
// charge register fields and values (ma units)
// ----------------------------------------------------------------
`define CHG_ILIM_LSB     0
`define CHG_ICHG_LSB     16
`define ILIM_PC_MA       16'h0064
`define ILIM_NONE_MA     16'hffff
`define ICHG_DEFAULT_MA  16'h03e8

// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define IRQ_FAULT        0
`define IRQ_TEMP         1
`define IRQ_WDOG         2
`define IRQ_SAFETY       3
`define IRQ_DONE         4
`define IRQ_BITS         5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ           20000000
`define FAULT_PULSE_US   128
`define FAULT_PULSE_CYC  ((`FAULT_PULSE_US * (`CLK_HZ / 1000000)))
`define SAFETY_MIN       27
// 64-bit arithmetic: the product overflows a 32-bit int
`define SAFETY_CYC       (64'(`SAFETY_MIN) * 64'(60) * 64'(`CLK_HZ))
`define WDOG_S           12
`define WDOG_CYC         (`WDOG_S * `CLK_HZ)

`endif

// ===== charger_pkg.sv
// charger_pkg.sv: shared types of the charger control logic
// assumes charger_cfg.svh is compiled alongside
package charger_pkg;
   typedef enum logic [1:0] {
      temp_ok,
      temp_warm,
      temp_suspend
   } temp_zone_e;
endpackage

// ===== charger_timer_if.sv
// charger_timer_if.sv: link between the control top and its timer block
// assumes both ends on sys_clk
`timescale 1ns/1ps
interface charger_timer_if;
   logic safety_restart;
   logic wdog_kick;
   logic host_mode;
   logic safety_expired;
   logic wdog_expired;

   modport ctrl  (output safety_restart, output wdog_kick,
                  output host_mode,
                  input  safety_expired, input wdog_expired);
   modport timer (input  safety_restart, input wdog_kick,
                  input  host_mode,
                  output safety_expired, output wdog_expired);
endinterface

// ===== charger_timers.sv
// charger_timers.sv: safety timer and host watchdog
// assumes restart and kick are one-cycle pulses on sys_clk
`timescale 1ns/1ps
`include "charger_cfg.svh"
module charger_timers
   import charger_pkg::*;
#(
   parameter longint SAFETY_CYCLES = `SAFETY_CYC,
   parameter longint WDOG_CYCLES   = `WDOG_CYC
) (
   input  wire logic   sys_clk,
   input  wire logic   rst,
   charger_timer_if.timer tif
);
   logic [35:0] safety_cnt;
   logic [31:0] wdog_cnt;
   wire  safety_hit = (safety_cnt == 36'(SAFETY_CYCLES - 1));
   wire  wdog_hit   = (wdog_cnt == 32'(WDOG_CYCLES - 1));

   // ----------------------------------------------------------------
   // safety timer: stops at expiry until restarted
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || tif.safety_restart) begin
         safety_cnt         <= '0;
         tif.safety_expired <= 1'b0;
      end else if (!tif.safety_expired) begin
         safety_cnt <= safety_cnt + 36'h1;
         if (safety_hit)
            tif.safety_expired <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // watchdog: only runs while the host holds control
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || tif.wdog_kick || !tif.host_mode) begin
         wdog_cnt         <= '0;
         tif.wdog_expired <= 1'b0;
      end else begin
         wdog_cnt         <= wdog_hit ? '0 : wdog_cnt + 32'h1;
         tif.wdog_expired <= wdog_hit;
      end
   end
endmodule

// ===== charger_ctrl.sv
// charger_ctrl.sv: pin control, status output and registers of the charger
// assumes synchronous pins, analog comparators as levels, wishbone master
//
// Functional notes
// - disable pin high stops charging, high-impedance mode
// - disable toggle restarts safety timer in default only
// - source pin high gives 100 mA input limit
// - source pin low: no limit, 1 A charge
// - status pin low while charging, else released
// - fault gives one 128 us status pulse
// - status enable bit gates all status activity
// - accessory switch follows host enable bit
// - default mode: cold or hot suspends charging
// - default mode: warm band lowers charge current
// - temperature faults readable by host
// - host mode: temperature only reported, not acted
// - 27 minute safety timer, 12 second watchdog
// - watchdog expiry returns to default unless safety expired, control and charge reset
// - host control or charge register write leaves default mode
`timescale 1ns/1ps
`include "charger_cfg.svh"
module charger_ctrl
   import charger_pkg::*;
#(
   parameter longint SAFETY_CYCLES = `SAFETY_CYC,
   parameter longint WDOG_CYCLES   = `WDOG_CYC,
   parameter int     PULSE_CYCLES  = `FAULT_PULSE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        charge_disable_in,
   input  wire logic        source_select_in,
   input  wire logic        temp_cold,
   input  wire logic        temp_hot,
   input  wire logic        temp_warm_in,
   input  wire logic        fault_in,
   input  wire logic        charge_done,
   output logic             charge_enable,
   output logic             high_z_mode,
   output logic      [15:0] input_limit_ma,
   output logic      [15:0] charge_current_ma,
   output logic             charge_reduce,
   output logic             accessory_power_out,
   output logic             stat_out,
   output logic             stat_oe,
   output logic             irq
);
   charger_timer_if tif ();

   charger_timers #(
      .SAFETY_CYCLES (SAFETY_CYCLES),
      .WDOG_CYCLES   (WDOG_CYCLES)
   ) u_timers (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tif     (tif)
   );

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] dis_sync;
   logic [1:0] ps_sync;
   logic       dis_last;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dis_sync <= 2'b00;
         ps_sync  <= 2'b00;
         dis_last <= 1'b0;
      end else begin
         dis_sync <= {dis_sync[0], charge_disable_in};
         ps_sync  <= {ps_sync[0], source_select_in};
         dis_last <= dis_sync[1];
      end
   end
   wire dis_level  = dis_sync[1];
   wire dis_toggle = dis_level ^ dis_last;
   wire ps_level   = ps_sync[1];

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic [31:0] control;
   logic [31:0] charge_reg;
   logic [`IRQ_BITS-1:0] irq_status;
   logic [`IRQ_BITS-1:0] irq_mask;
   logic        host_mode;
   logic        strap_pending;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr  = bus_req && wb_we_i;
   wire wr_ctl  = bus_wr && (wb_adr_i == `REG_CONTROL);
   wire wr_chg  = bus_wr && (wb_adr_i == `REG_CHARGE);
   wire wr_ist  = bus_wr && (wb_adr_i == `REG_IRQ_STATUS);
   wire wr_msk  = bus_wr && (wb_adr_i == `REG_IRQ_MASK);
   wire host_wr = wr_ctl || wr_chg;
   wire go_default = tif.wdog_expired && !tif.safety_expired;

   // ----------------------------------------------------------------
   // start-up defaults by source selection
   // ----------------------------------------------------------------
   wire [15:0] dflt_ilim = ps_level ? `ILIM_PC_MA
                                    : `ILIM_NONE_MA;
   wire [31:0] dflt_charge = {`ICHG_DEFAULT_MA, dflt_ilim};

   // ----------------------------------------------------------------
   // control and charge registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || go_default) begin
         control       <= `CTL_RESET_VAL;
         host_mode     <= 1'b0;
         strap_pending <= 1'b1;
      end else if (host_wr) begin
         host_mode     <= 1'b1;
         strap_pending <= 1'b0;
         if (wr_ctl)
            control <= merge(control, wb_dat_i, wb_sel_i);
      end
   end

   // default values follow the source pin until the host takes over;
   // a strap caught after reset, not at it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         charge_reg <= '0;
      end else if (wr_chg) begin
         charge_reg <= merge(charge_reg, wb_dat_i, wb_sel_i);
      end else if (!host_mode || strap_pending) begin
         charge_reg <= dflt_charge;
      end
   end

   // ----------------------------------------------------------------
   // temperature zones
   // ----------------------------------------------------------------
   temp_zone_e zone;
   assign zone = (temp_cold || temp_hot) ? temp_suspend :
                 temp_warm_in            ? temp_warm : temp_ok;
   wire temp_fault = (zone != temp_ok);
   // host mode ignores zones for charging, they only reach the status
   wire temp_block = !host_mode && (zone == temp_suspend);
   wire temp_slow  = !host_mode && (zone == temp_warm);

   wire chg_allow = !dis_level && !temp_block && !tif.safety_expired
                    && (!host_mode || control[`CTL_CHG_EN]);
   wire charging  = chg_allow && !charge_done;

   // ----------------------------------------------------------------
   // timer controls
   // ----------------------------------------------------------------
   assign tif.safety_restart = (dis_toggle && !host_mode)
                               || go_default || rst;
   assign tif.wdog_kick      = bus_req;
   assign tif.host_mode      = host_mode;

   // ----------------------------------------------------------------
   // fault pulse: rising edge only, so a stuck fault pulses once
   // ----------------------------------------------------------------
   logic fault_last;
   logic temp_last;
   logic [15:0] pulse_cnt;
   wire  fault_now  = fault_in || temp_fault || tif.safety_expired;
   wire  fault_rise = fault_now && !fault_last;
   wire  pulse_on   = (pulse_cnt != 16'h0);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_last <= 1'b0;
         temp_last  <= 1'b0;
         pulse_cnt  <= '0;
      end else begin
         fault_last <= fault_now;
         temp_last  <= temp_fault;
         if (fault_rise)
            pulse_cnt <= 16'(PULSE_CYCLES);
         else if (pulse_on)
            pulse_cnt <= pulse_cnt - 16'h1;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status: set wins over write-one clear
   // ----------------------------------------------------------------
   logic done_last;
   logic safety_last;
   logic [`IRQ_BITS-1:0] irq_set;
   always_comb begin
      irq_set               = '0;
      irq_set[`IRQ_FAULT]   = fault_rise;
      irq_set[`IRQ_TEMP]    = temp_fault && !temp_last;
      irq_set[`IRQ_WDOG]    = tif.wdog_expired;
      irq_set[`IRQ_SAFETY]  = tif.safety_expired && !safety_last;
      irq_set[`IRQ_DONE]    = charge_done && !done_last;
   end
   wire [`IRQ_BITS-1:0] irq_clr = wr_ist ? wb_dat_i[`IRQ_BITS-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask   <= '0;
         done_last  <= 1'b0;
         safety_last <= 1'b0;
      end else begin
         done_last  <= charge_done;
         safety_last <= tif.safety_expired;
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_msk)
            irq_mask <= wb_dat_i[`IRQ_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [31:0] status_word = {24'h0, tif.wdog_expired, tif.safety_expired,
                              host_mode, zone, dis_level, ps_level, charging};
   logic [31:0] rd_data;
   always_comb begin
      unique case (wb_adr_i)
         `REG_CONTROL:    rd_data = control;
         `REG_CHARGE:     rd_data = charge_reg;
         `REG_STATUS:     rd_data = status_word;
         `REG_IRQ_STATUS: rd_data = {{(32-`IRQ_BITS){1'b0}}, irq_status};
         `REG_IRQ_MASK:   rd_data = {{(32-`IRQ_BITS){1'b0}}, irq_mask};
         default:         rd_data = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   wire stat_low = control[`CTL_STAT_EN]
                   && (charging ^ pulse_on);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o            <= 1'b0;
         wb_dat_o            <= '0;
         charge_enable       <= 1'b0;
         high_z_mode         <= 1'b1;
         input_limit_ma      <= '0;
         charge_current_ma   <= '0;
         charge_reduce       <= 1'b0;
         accessory_power_out <= 1'b0;
         stat_out            <= 1'b0;
         stat_oe             <= 1'b1;
         irq                 <= 1'b0;
      end else begin
         wb_ack_o            <= bus_req;
         wb_dat_o            <= bus_req ? rd_data : '0;
         charge_enable       <= chg_allow;
         high_z_mode         <= dis_level;
         input_limit_ma      <= charge_reg[`CHG_ILIM_LSB +: 16];
         charge_current_ma   <= charge_reg[`CHG_ICHG_LSB +: 16];
         charge_reduce       <= temp_slow;
         accessory_power_out <= control[`CTL_ACC_EN];
         stat_out            <= 1'b0;
         stat_oe             <= !stat_low;
         irq                 <= |(irq_status & irq_mask);
      end
   end
endmodule

// ===== charger_ctrl_sva.sv
// charger_ctrl_sva.sv: port checks of the charger control top
// assumes a bind onto charger_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
`include "charger_cfg.svh"
module charger_ctrl_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        charge_disable_in,
   input wire logic        source_select_in,
   input wire logic        temp_warm_in,
   input wire logic        charge_enable,
   input wire logic        high_z_mode,
   input wire logic [15:0] input_limit_ma,
   input wire logic [15:0] charge_current_ma,
   input wire logic        charge_reduce,
   input wire logic        stat_out
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence req_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence boot_pc;
      $fell(rst) && source_select_in;
   endsequence
   sequence boot_ac;
      $fell(rst) && !source_select_in;
   endsequence
   chk_ack_latency: assert property (
      req_taken |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after the request");
   chk_ack_cause: assert property (
      $rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
      else $error("ack without a request");
   chk_dat_idle: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_hiz_disable: assert property (
      charge_disable_in [*5] |-> high_z_mode && !charge_enable)
      else $error("disable pin did not stop charging");
   chk_hiz_enable: assert property (
      !charge_disable_in [*5] |-> !high_z_mode)
      else $error("high impedance mode without disable pin");
   chk_pc_limit: assert property (
      boot_pc |-> ##[1:8] input_limit_ma == `ILIM_PC_MA)
      else $error("usb start without 100 mA limit");
   chk_ac_defaults: assert property (
      boot_ac |-> ##[1:8] input_limit_ma == `ILIM_NONE_MA &&
      charge_current_ma == `ICHG_DEFAULT_MA)
      else $error("adapter start defaults wrong");
   chk_reduce_warm: assert property (
      !temp_warm_in [*4] |-> !charge_reduce)
      else $error("charge reduced outside warm band");
   chk_drain_low: assert property (stat_out == 1'b0)
      else $error("status pin data not low");
endmodule

// ===== charger_host_model.sv
// charger_host_model.sv: host processor on the register bus
// assumes a classic wishbone slave on sys_clk
`timescale 1ns/1ps
module charger_host_model (
   input  wire logic        sys_clk,
   input  wire logic        wb_ack_o,
   input  wire logic [31:0] wb_dat_o,
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic      [7:0]  wb_adr_i,
   output logic      [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_i
);
   // ----------------------------------------------------------------
   // bus cycle
   // ----------------------------------------------------------------
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 7'h0;
      {wb_adr_i, wb_dat_i} = 40'h0;
   end
   // host takes control by writing the control or charge register
   task automatic cycle(input logic we, input logic [7:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= wd;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // released lines flip so a stale value never passes
      wb_adr_i <= ~adr;
      wb_dat_i <= ~wd;
   endtask
endmodule

// ===== charger_pin_control_status_tb_top.sv
// charger_pin_control_status_tb_top.sv: self-checking charger bench
// assumes charger_ctrl with shortened timers and the host bus model
`timescale 1ns/1ps
`include "charger_cfg.svh"
module charger_pin_control_status_tb_top;
   localparam int SAFE  = 600;
   localparam int WDOG  = 100;
   localparam int PULSE = 8;
   logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic charge_disable_in, source_select_in, temp_cold, temp_hot;
   logic temp_warm_in, fault_in, charge_done, charge_enable;
   logic high_z_mode, charge_reduce, accessory_power_out;
   logic stat_out, stat_oe, irq;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd, d;
   logic [15:0] input_limit_ma, charge_current_ma;
   int          fails = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n;
   integer      seed;
   charger_ctrl #(.SAFETY_CYCLES(SAFE), .WDOG_CYCLES(WDOG),
      .PULSE_CYCLES(PULSE)) uut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .charge_disable_in, .source_select_in, .temp_cold, .temp_hot,
      .temp_warm_in, .fault_in, .charge_done, .charge_enable,
      .high_z_mode, .input_limit_ma, .charge_current_ma, .charge_reduce,
      .accessory_power_out, .stat_out, .stat_oe, .irq);
   charger_host_model host (.sys_clk, .wb_ack_o, .wb_dat_o, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] exp_ilim(input logic src);
      return src ? `ILIM_PC_MA : `ILIM_NONE_MA;
   endfunction
   function automatic logic [1:0] exp_zone(input logic w, input logic h);
      return h ? 2'h2 : {1'b0, w};
   endfunction
   task automatic check(input string what, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      host.cycle(1'b1, a, v, rd);
   endtask
   task automatic rdr(input logic [7:0] a);
      host.cycle(1'b0, a, 32'h0, rd);
   endtask
   task automatic count_low(output int k);
      k = 0;
      repeat (20) begin
         tick(1);
         k += (stat_oe === 1'b0);
      end
   endtask
   task automatic done_test(input string s);
      $display("test %s ended, mismatches so far %0d", s, fails);
   endtask
   task automatic do_reset(input logic src);
      @(posedge sys_clk);
      rst <= 1'b1;
      source_select_in <= src;
      tick(20);
      @(posedge sys_clk);
      rst <= 1'b0;
      tick(6);
   endtask
   task automatic complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run;
      end
   end
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'hda21;
      {rst, source_select_in} = 2'h3;
      {charge_disable_in, temp_cold, temp_hot} = 3'h0;
      {temp_warm_in, fault_in, charge_done} = 3'h0;
      do_reset(1'b1);
      check("ilim", exp_ilim(1'b1), input_limit_ma);
      check("stat", 1'b0, stat_oe);
      rdr(`REG_CONTROL);
      check("control", `CTL_RESET_VAL, rd);
      rdr(8'h40);
      check("unmapped", 32'h0, rd);
      done_test("boot");
      @(posedge sys_clk);
      charge_disable_in <= 1'b1;
      tick(6);
      check("hiz", 1'b1, high_z_mode);
      check("stat off", 1'b1, stat_oe);
      @(posedge sys_clk);
      fault_in <= 1'b1;
      count_low(n);
      check("pulse", PULSE, n);
      count_low(n);
      check("repeat", 32'h0, n);
      @(posedge sys_clk);
      fault_in <= 1'b0;
      charge_disable_in <= 1'b0;
      tick(6);
      check("enable", 1'b1, charge_enable);
      done_test("pulse");
      @(posedge sys_clk);
      temp_warm_in <= 1'b1;
      tick(4);
      check("reduce", 1'b1, charge_reduce);
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         temp_cold <= (i == 0);
         temp_hot <= (i == 1);
         tick(4);
         check("suspend", 1'b0, charge_enable);
         rdr(`REG_STATUS);
         check("zone", exp_zone(1'b1, 1'b1), rd[4:3]);
      end
      @(posedge sys_clk);
      {temp_cold, temp_hot, temp_warm_in} <= 3'h0;
      charge_done <= 1'b1;
      tick(4);
      check("done", 1'b1, stat_oe);
      @(posedge sys_clk);
      charge_done <= 1'b0;
      wr(`REG_IRQ_MASK, 32'h0);
      rdr(`REG_IRQ_STATUS);
      check("temp flag", 1'b1, rd[`IRQ_TEMP]);
      check("masked", 1'b0, irq);
      wr(`REG_IRQ_MASK, 32'h2);
      tick(2);
      check("irq", 1'b1, irq);
      wr(`REG_IRQ_STATUS, 32'h1f);
      tick(2);
      check("irq clear", 1'b0, irq);
      done_test("temperature");
      // toggles closer than the timer length keep it from running out
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         charge_disable_in <= 1'b1;
         tick(5);
         @(posedge sys_clk);
         charge_disable_in <= 1'b0;
         tick(SAFE * 2 / 3);
      end
      rdr(`REG_STATUS);
      check("safety held", 1'b0, rd[6]);
      tick(SAFE);
      rdr(`REG_STATUS);
      check("safety out", 1'b1, rd[6]);
      rdr(`REG_IRQ_STATUS);
      check("safety flag", 1'b1, rd[`IRQ_SAFETY]);
      done_test("safety");
      do_reset(1'b0);
      check("ilim ac", exp_ilim(1'b0), input_limit_ma);
      check("ichg", `ICHG_DEFAULT_MA, charge_current_ma);
      wr(`REG_CONTROL, 32'h6);
      tick(3);
      check("acc on", 1'b1, accessory_power_out);
      @(posedge sys_clk);
      {temp_hot, fault_in} <= 2'h3;
      count_low(n);
      check("gated", 32'h0, n);
      check("host temp", 1'b1, charge_enable);
      rdr(`REG_STATUS);
      check("host", 1'b1, rd[5]);
      check("host zone", exp_zone(1'b0, 1'b1), rd[4:3]);
      @(posedge sys_clk);
      {temp_hot, fault_in} <= 2'h0;
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'h0000_ffff : $random(seed);
         wr(`REG_CHARGE, d);
         tick(3);
         check("host ilim", d[15:0], input_limit_ma);
         check("host ichg", d[31:16], charge_current_ma);
      end
      tick(WDOG + 30);
      check("acc off", 1'b0, accessory_power_out);
      rdr(`REG_CONTROL);
      check("ctl back", `CTL_RESET_VAL, rd);
      rdr(`REG_STATUS);
      check("default", 1'b0, rd[5]);
      rdr(`REG_IRQ_STATUS);
      check("wdog flag", 1'b1, rd[`IRQ_WDOG]);
      done_test("host");
      complete_run;
   end
endmodule
bind charger_ctrl charger_ctrl_sva chk (.sys_clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .wb_dat_o, .charge_disable_in,
   .source_select_in, .temp_warm_in, .charge_enable, .high_z_mode,
   .input_limit_ma, .charge_current_ma, .charge_reduce, .stat_out);
